// ---- cll_consts.svh ----
// Constants for the current loop logging control block
//
// Overview of operation
// - Stop-when-full policy halts recording at full memory and raises a warning until acknowledged.
// - A pending full or overwrite warning is raised again at every power-up.
// - After a stop-when-full halt, recording resumes only once memory is downloaded and freed.
// - Downloading before memory is full prevents any full or overwrite warning.
// - Wraparound policy keeps writing from the first location, overwriting oldest records.
// - Wraparound policy raises an acknowledge-required warning at the first overwrite.
// - At full memory, status shows recording-stopped or overwriting-data per the policy.
// - Unconditional gating stores a sample per recorded channel every interval.
// - High-level gating stores interval samples only while the gating input is high.
// - Low-level gating stores interval samples only while the gating input is low.
// - Recording interval is one of fifteen choices from one second to one hour.
// - Recording instants align to the clock as exact multiples within minute or hour.
// - Each of eight channels records nothing, the instantaneous value or the average.
// - A channel with an inactive input is never recorded.
// - Input range is inactive, 0-20 mA or 4-20 mA; result scaled from end values.
// - Range minimum maps to the low end value, maximum to the high end value.
// - A low end above the high end gives a result falling with rising current.
// - Decimal position selects zero to three fractional digits of the result.
// - Smoothing level zero means no filtering, five the longest time constant.
// - Current outside the extended window shows an over or under range indication.
// - Lower margin below 4 mA, up to 3.99 mA, applies only in 4-20 mA range.
// - Upper margin above 20 mA, up to 1.99 mA; both margins in 0.01 mA steps.
`ifndef CLL_CONSTS_SVH
`define CLL_CONSTS_SVH

// ----------------------------------------------------------------
// Current scale, all currents in 0.01 mA steps
// ----------------------------------------------------------------
`define CLL_CUR_FULL      12'h7D0
`define CLL_CUR_OFS_MIN   12'h190
`define CLL_SPAN_0_20     12'h7D0
`define CLL_SPAN_4_20     12'h640
`define CLL_FILT_FRAC     4
`define CLL_FILT_MAX      3'h5

// ----------------------------------------------------------------
// Record memory
// ----------------------------------------------------------------
`define CLL_MEM_DEPTH     13'h1000
`define CLL_MEM_LAST      12'hFFF
`define CLL_CNT_SAT       16'hFFFF
`define CLL_NUM_CH        8
`define CLL_LAST_CH       3'h7

// ----------------------------------------------------------------
// Recording interval table, codes 0-6 seconds, 7-13 minutes, 14 hour
// ----------------------------------------------------------------
`define CLL_PER_SEC_LAST  4'h6
`define CLL_PER_MIN_LAST  4'hD
`define CLL_PER_HOUR      4'hE

`endif

// ---- cll_logging_ctrl.sv ----
// Current loop logging control: conditioning, record scheduling, memory policy
`include "cll_consts.svh"

module cll_logging_ctrl (
  input  wire logic               mclk_i,
  input  wire logic               srst_i,
  input  wire logic               sample_valid_i,
  input  wire logic [2:0]         sample_chan_i,
  input  wire logic [11:0]        sample_cur_i,
  input  wire logic [7:0][1:0]    in_type_i,
  input  wire logic [7:0][1:0]    rec_sel_i,
  input  wire logic [7:0][2:0]    filt_lvl_i,
  input  wire logic [7:0][14:0]   upper_end_scale_i,
  input  wire logic [7:0][14:0]   lower_end_scale_i,
  input  wire logic [7:0][1:0]    dec_pos_i,
  input  wire logic [7:0][7:0]    upper_ext_i,
  input  wire logic [7:0][8:0]    lower_ext_i,
  input  wire logic [1:0]         gate_mode_i,
  input  wire logic               full_policy_i,
  input  wire logic [3:0]         rec_period_i,
  input  wire logic               rtc_tick_i,
  input  wire logic [5:0]         rtc_sec_i,
  input  wire logic [5:0]         rtc_min_i,
  input  wire logic               gate_pin_i,
  input  wire logic               warn_ack_i,
  input  wire logic               power_up_i,
  input  wire logic               download_done_i,
  output logic                    meas_valid_o,
  output logic [2:0]              meas_chan_o,
  output logic [15:0]             meas_value_o,
  output logic [1:0]              meas_flag_o,
  output logic [1:0]              meas_dp_o,
  output logic                    rec_wr_o,
  output logic [11:0]             rec_addr_o,
  output logic [2:0]              rec_chan_o,
  output logic [11:0]             rec_data_o,
  output logic                    rec_avg_o,
  output logic                    warn_o,
  output logic [1:0]              mem_status_o,
  output logic [12:0]             used_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Interval length within its unit for codes of the second and minute groups
  function automatic logic [5:0] cll_per_len(input logic [2:0] idx);
    logic [5:0] len;
    len = 6'h01;
    case (idx)
      3'h0:    len = 6'h01;
      3'h1:    len = 6'h02;
      3'h2:    len = 6'h05;
      3'h3:    len = 6'h0A;
      3'h4:    len = 6'h0F;
      3'h5:    len = 6'h14;
      default: len = 6'h1E;
    endcase
    return len;
  endfunction : cll_per_len

  // True at a clock instant that is an exact multiple of the interval
  function automatic logic cll_due(input logic [3:0] code, input logic [5:0] sec,
                                   input logic [5:0] mnt);
    logic [3:0] mcode;
    mcode = code - 4'h7;
    if (code <= `CLL_PER_SEC_LAST)
      return (sec % cll_per_len(code[2:0])) == 6'h00;
    else if (code <= `CLL_PER_MIN_LAST)
      return (sec == 6'h00) && ((mnt % cll_per_len(mcode[2:0])) == 6'h00);
    else if (code == `CLL_PER_HOUR)
      return (sec == 6'h00) && (mnt == 6'h00);
    else
      return 1'b0;
  endfunction : cll_due

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                gate_meta_r;
  logic                gate_sync_r;
  logic [17:0]         filt_r [`CLL_NUM_CH];
  logic [27:0]         sum_r  [`CLL_NUM_CH];
  logic [15:0]         cnt_r  [`CLL_NUM_CH];
  cll_pkg::cll_state_e st_r;
  cll_pkg::cll_state_e st_nxt;
  logic [2:0]          idx_r;
  logic [11:0]         wr_ptr_r;
  logic [12:0]         used_r;
  logic                stopped_r;
  logic                ovw_r;
  logic                warn_r;
  logic [1:0]          mstat_r;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // Gate pin crossing; only the second stage is read
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      gate_meta_r <= 1'b0;
      gate_sync_r <= 1'b0;
    end
    else
    begin
      gate_meta_r <= gate_pin_i;
      gate_sync_r <= gate_meta_r;
    end
  end

  // First-order smoothing with shift equal to level; four fraction bits keep slow settling
  wire logic [2:0]  lvl_raw  = filt_lvl_i[sample_chan_i];
  wire logic [2:0]  lvl      = (lvl_raw > `CLL_FILT_MAX) ? `CLL_FILT_MAX : lvl_raw;
  wire logic [17:0] filt_old = filt_r[sample_chan_i];
  wire logic signed [17:0] filt_dif = $signed({2'b00, sample_cur_i, 4'h0}) - $signed(filt_old);
  wire logic [17:0] filt_nxt = filt_old + 18'(filt_dif >>> lvl);
  wire logic [11:0] fcur_nxt = filt_nxt[`CLL_FILT_FRAC +: 12];

  // ----------------------------------------------------------------
  // Scaling and window check of each filtered reading
  // ----------------------------------------------------------------
  cll_scale u_scale (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (sample_valid_i),
    .in_chan_i   (sample_chan_i),
    .in_cur_i    (fcur_nxt),
    .range_i     (in_type_i[sample_chan_i]),
    .lo_i        (lower_end_scale_i[sample_chan_i]),
    .hi_i        (upper_end_scale_i[sample_chan_i]),
    .dp_i        (dec_pos_i[sample_chan_i]),
    .uext_i      (upper_ext_i[sample_chan_i]),
    .lext_i      (lower_ext_i[sample_chan_i]),
    .out_valid_o (meas_valid_o),
    .out_chan_o  (meas_chan_o),
    .out_value_o (meas_value_o),
    .out_flag_o  (meas_flag_o),
    .out_dp_o    (meas_dp_o)
  );

  // ----------------------------------------------------------------
  // Record scheduler
  // ----------------------------------------------------------------
  wire logic stop_pol = (full_policy_i == cll_pkg::CLL_FULL_STOP);
  wire logic full     = (used_r == `CLL_MEM_DEPTH);
  wire logic gate_ok  = (gate_mode_i == cll_pkg::CLL_GATE_ALWAYS) ||
                        ((gate_mode_i == cll_pkg::CLL_GATE_HIGH) && gate_sync_r) ||
                        ((gate_mode_i == cll_pkg::CLL_GATE_LOW) && !gate_sync_r);
  wire logic due      = rtc_tick_i && cll_due(rec_period_i, rtc_sec_i, rtc_min_i);
  wire logic start    = (st_r == cll_pkg::CLL_ST_IDLE) && due && gate_ok && !stopped_r;
  // Inactive inputs drop out of the recorded set whatever the selection says
  wire logic ch_en    = (rec_sel_i[idx_r] != cll_pkg::CLL_REC_NONE) &&
                        (in_type_i[idx_r] != cll_pkg::CLL_RANGE_OFF);
  wire logic wr_fire  = (st_r == cll_pkg::CLL_ST_EMIT) && ch_en && !(stop_pol && full);
  wire logic use_avg  = (rec_sel_i[idx_r] == cll_pkg::CLL_REC_AVG) && (cnt_r[idx_r] != 16'h0000);
  wire logic [27:0] avg_val = sum_r[idx_r] / {12'h000, cnt_r[idx_r]};
  wire logic [11:0] inst_val = filt_r[idx_r][`CLL_FILT_FRAC +: 12];

  // Scan all eight channels, one per cycle; a due tick that arrives during this scan starts nothing
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      cll_pkg::CLL_ST_IDLE: if (start) st_nxt = cll_pkg::CLL_ST_EMIT;
      cll_pkg::CLL_ST_EMIT: if (idx_r == `CLL_LAST_CH) st_nxt = cll_pkg::CLL_ST_IDLE;
      default:              st_nxt = cll_pkg::CLL_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_r  <= cll_pkg::CLL_ST_IDLE;
      idx_r <= 3'h0;
    end
    else
    begin
      st_r  <= st_nxt;
      idx_r <= (st_r == cll_pkg::CLL_ST_EMIT) ? idx_r + 3'h1 : 3'h0;
    end
  end

  // Per-channel filter state and running average since the last record
  always_ff @(posedge mclk_i)
  begin
    for (int c = 0; c < `CLL_NUM_CH; c++)
    begin
      if (srst_i)
      begin
        filt_r[c] <= 18'h00000;
        sum_r[c]  <= 28'h0000000;
        cnt_r[c]  <= 16'h0000;
      end
      else
      begin
        if (sample_valid_i && sample_chan_i == 3'(c))
          filt_r[c] <= filt_nxt;
        if ((st_r == cll_pkg::CLL_ST_EMIT) && idx_r == 3'(c) && ch_en)
        begin
          // Reading of the same cycle opens the next average instead of being lost
          sum_r[c] <= (sample_valid_i && sample_chan_i == 3'(c)) ? {16'h0000, fcur_nxt} : 28'h0;
          cnt_r[c] <= (sample_valid_i && sample_chan_i == 3'(c)) ? 16'h0001 : 16'h0000;
        end
        else if (sample_valid_i && sample_chan_i == 3'(c) && cnt_r[c] != `CLL_CNT_SAT)
        begin
          sum_r[c] <= sum_r[c] + {16'h0000, fcur_nxt};
          cnt_r[c] <= cnt_r[c] + 16'h0001;
        end
      end
    end
  end

  // Record output port
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rec_wr_o   <= 1'b0;
      rec_addr_o <= 12'h000;
      rec_chan_o <= 3'h0;
      rec_data_o <= 12'h000;
      rec_avg_o  <= 1'b0;
    end
    else
    begin
      rec_wr_o   <= wr_fire;
      rec_addr_o <= wr_ptr_r;
      rec_chan_o <= idx_r;
      rec_data_o <= use_avg ? avg_val[11:0] : inst_val;
      rec_avg_o  <= use_avg;
    end
  end

  // ----------------------------------------------------------------
  // Memory policy and warning
  // ----------------------------------------------------------------
  wire logic fill_last = wr_fire && stop_pol && (used_r == `CLL_MEM_DEPTH - 13'h1);
  wire logic first_ovw = wr_fire && !stop_pol && full && !ovw_r;
  // Warning comes back at power-up while its cause is still there
  wire logic warn_set  = fill_last || first_ovw || (power_up_i && (stopped_r || ovw_r));
  wire logic [12:0] used_nxt = download_done_i ? {12'h000, wr_fire} :
                               (wr_fire && !full) ? used_r + 13'h1 : used_r;
  wire logic [1:0]  mstat_nxt = !full ? cll_pkg::CLL_MEM_NORMAL :
                                stop_pol ? cll_pkg::CLL_MEM_STOPPED : cll_pkg::CLL_MEM_OVERWRITE;

  // Set beats acknowledge and download in the same cycle so no event is lost
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_r  <= 12'h000;
      used_r    <= 13'h0000;
      stopped_r <= 1'b0;
      ovw_r     <= 1'b0;
      warn_r    <= 1'b0;
      mstat_r   <= cll_pkg::CLL_MEM_NORMAL;
    end
    else
    begin
      if (wr_fire)
        wr_ptr_r <= (wr_ptr_r == `CLL_MEM_LAST) ? 12'h000 : wr_ptr_r + 12'h001;
      used_r    <= used_nxt;
      stopped_r <= fill_last || (stopped_r && !download_done_i);
      ovw_r     <= first_ovw || (ovw_r && !download_done_i);
      warn_r    <= warn_set || (warn_r && !warn_ack_i && !download_done_i);
      mstat_r   <= mstat_nxt;
    end
  end

  assign warn_o       = warn_r;
  assign mem_status_o = mstat_r;
  assign used_o       = used_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stop_halts: assert property (@(posedge mclk_i) disable iff (srst_i)
    (stop_pol && full) |=> !rec_wr_o)
    else $error("record written while halted on full memory");

  a_full_warns: assert property (@(posedge mclk_i) disable iff (srst_i)
    fill_last |=> (warn_o && stopped_r && used_o == `CLL_MEM_DEPTH))
    else $error("full memory did not halt and warn");

  a_warn_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
    (warn_o && !warn_ack_i && !download_done_i) |=> warn_o)
    else $error("warning dropped without acknowledge");

  a_power_rewarn: assert property (@(posedge mclk_i) disable iff (srst_i)
    (power_up_i && (stopped_r || ovw_r)) |=> warn_o)
    else $error("pending warning not raised at power-up");

  a_resume_free: assert property (@(posedge mclk_i) disable iff (srst_i)
    download_done_i |=> (!stopped_r && used_o <= 13'h0001))
    else $error("download did not free memory");

  a_warn_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(warn_o) |-> (used_o == `CLL_MEM_DEPTH))
    else $error("warning raised before memory full");

  a_wrap_addr: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_fire && wr_ptr_r == `CLL_MEM_LAST) |=> (wr_ptr_r == 12'h000))
    else $error("write pointer did not wrap to first location");

  a_ovw_warns: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_fire && !stop_pol && full && !ovw_r) |=> (warn_o && ovw_r))
    else $error("first overwrite not warned");

  a_status_full: assert property (@(posedge mclk_i) disable iff (srst_i)
    (full && !stop_pol && !download_done_i) |=> (mem_status_o == cll_pkg::CLL_MEM_OVERWRITE))
    else $error("overwrite status missing at full memory");

  a_gate_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_r == cll_pkg::CLL_ST_IDLE && gate_mode_i == cll_pkg::CLL_GATE_HIGH && !gate_sync_r)
    |=> (st_r == cll_pkg::CLL_ST_IDLE))
    else $error("recording started with gate input low");

  a_gate_low: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_r == cll_pkg::CLL_ST_IDLE && gate_mode_i == cll_pkg::CLL_GATE_LOW && gate_sync_r)
    |=> (st_r == cll_pkg::CLL_ST_IDLE))
    else $error("recording started with gate input high");

  a_tick_align: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_r == cll_pkg::CLL_ST_IDLE && !due)
    |=> (st_r == cll_pkg::CLL_ST_IDLE))
    else $error("recording started off an interval instant");

  a_scan_step: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_r == cll_pkg::CLL_ST_EMIT && idx_r != `CLL_LAST_CH)
    |=> (st_r == cll_pkg::CLL_ST_EMIT && idx_r == $past(idx_r) + 3'h1))
    else $error("channel scan skipped a step");

  a_inactive_skip: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_r == cll_pkg::CLL_ST_EMIT && in_type_i[idx_r] == cll_pkg::CLL_RANGE_OFF)
    |=> !rec_wr_o)
    else $error("inactive channel recorded");

  a_filter_bypass: assert property (@(posedge mclk_i) disable iff (srst_i)
    (sample_valid_i && lvl == 3'h0) |-> (fcur_nxt == sample_cur_i))
    else $error("smoothing applied at level zero");

  a_stop_status: assert property (@(posedge mclk_i) disable iff (srst_i)
    (full && stop_pol && !download_done_i)
    |=> (mem_status_o == cll_pkg::CLL_MEM_STOPPED))
    else $error("stopped status missing at full memory");

endmodule : cll_logging_ctrl

// ---- cll_pkg.sv ----
// Types shared by the current loop logging control block
package cll_pkg;

  // Input range selection
  typedef enum logic [1:0] {CLL_RANGE_OFF, CLL_RANGE_0_20, CLL_RANGE_4_20} cll_range_e;
  // Per-channel record selection
  typedef enum logic [1:0] {CLL_REC_NONE, CLL_REC_INST, CLL_REC_AVG} cll_rec_e;
  // Recording gate mode
  typedef enum logic [1:0] {CLL_GATE_ALWAYS, CLL_GATE_HIGH, CLL_GATE_LOW} cll_gate_e;
  // Memory-full policy
  typedef enum logic {CLL_FULL_STOP, CLL_FULL_WRAP} cll_full_e;
  // Memory status in place of remaining time
  typedef enum logic [1:0] {CLL_MEM_NORMAL, CLL_MEM_STOPPED, CLL_MEM_OVERWRITE} cll_mstat_e;
  // Reading indication
  typedef enum logic [1:0] {CLL_FLAG_OK, CLL_FLAG_OVER, CLL_FLAG_UNDER} cll_flag_e;
  // Record scheduler states
  typedef enum logic {CLL_ST_IDLE, CLL_ST_EMIT} cll_state_e;

endpackage : cll_pkg

// ---- cll_scale.sv ----
// Linear end-value scaler and extended window check for one reading
`include "cll_consts.svh"

module cll_scale (
  input  wire logic               mclk_i,
  input  wire logic               srst_i,
  input  wire logic               in_valid_i,
  input  wire logic [2:0]         in_chan_i,
  input  wire logic [11:0]        in_cur_i,
  input  wire logic [1:0]         range_i,
  input  wire logic [14:0]        lo_i,
  input  wire logic [14:0]        hi_i,
  input  wire logic [1:0]         dp_i,
  input  wire logic [7:0]         uext_i,
  input  wire logic [8:0]         lext_i,
  output logic                    out_valid_o,
  output logic [2:0]              out_chan_o,
  output logic [15:0]             out_value_o,
  output logic [1:0]              out_flag_o,
  output logic [1:0]              out_dp_o
);

  // ----------------------------------------------------------------
  // Window and scaling arithmetic
  // ----------------------------------------------------------------
  // Offset range starts at 4 mA, full range at 0 mA
  wire logic        ofs_rng   = (range_i == cll_pkg::CLL_RANGE_4_20);
  wire logic [11:0] cur_min   = ofs_rng ? `CLL_CUR_OFS_MIN : 12'h000;
  wire logic [11:0] span      = ofs_rng ? `CLL_SPAN_4_20 : `CLL_SPAN_0_20;
  wire logic [12:0] up_lim    = {1'b0, `CLL_CUR_FULL} + {5'h00, uext_i};
  wire logic [12:0] lo_lim    = {1'b0, `CLL_CUR_OFS_MIN} - {4'h0, lext_i};
  wire logic        over      = {1'b0, in_cur_i} > up_lim;
  // Lower margin only matters in the offset range
  wire logic        under     = ofs_rng && ({1'b0, in_cur_i} < lo_lim);
  wire logic signed [31:0] lo_s  = 32'($signed(lo_i));
  wire logic signed [31:0] dif_s = 32'($signed(hi_i)) - lo_s;
  wire logic signed [31:0] off_s = $signed({20'h00000, in_cur_i}) - $signed({20'h00000, cur_min});
  // Negative span from a low end above the high end falls naturally out of the sign
  wire logic signed [31:0] val_s = lo_s + (dif_s * off_s) / $signed({20'h00000, span});
  wire logic [1:0]  flag_nxt  = over ? cll_pkg::CLL_FLAG_OVER :
                                under ? cll_pkg::CLL_FLAG_UNDER : cll_pkg::CLL_FLAG_OK;

  // Output register; inactive inputs give no reading
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      out_valid_o <= 1'b0;
      out_chan_o  <= 3'h0;
      out_value_o <= 16'h0000;
      out_flag_o  <= cll_pkg::CLL_FLAG_OK;
      out_dp_o    <= 2'h0;
    end
    else
    begin
      out_valid_o <= in_valid_i && (range_i != cll_pkg::CLL_RANGE_OFF);
      out_chan_o  <= in_chan_i;
      out_value_o <= val_s[15:0];
      out_flag_o  <= flag_nxt;
      out_dp_o    <= dp_i;
    end
  end

  a_over_flag: assert property (@(posedge mclk_i) disable iff (srst_i)
    (in_valid_i && range_i != cll_pkg::CLL_RANGE_OFF && {1'b0, in_cur_i} > up_lim)
    |=> (out_valid_o && out_flag_o == cll_pkg::CLL_FLAG_OVER))
    else $error("over range reading not flagged");

  a_low_end_map: assert property (@(posedge mclk_i) disable iff (srst_i)
    (in_valid_i && range_i == cll_pkg::CLL_RANGE_4_20 && in_cur_i == `CLL_CUR_OFS_MIN)
    |=> (out_value_o == 16'($signed($past(lo_i)))))
    else $error("range minimum did not map to low end value");

endmodule : cll_scale

// ---- cll_sensor_model.sv ----
// Model of the loop sensors and the gating digital input
module cll_sensor_model (
  input  wire logic        mclk_i,
  input  wire logic        req_i,
  input  wire logic [11:0] cur_i,
  input  wire logic        lvl_i,
  output logic             valid_o,
  output logic [11:0]      cur_o,
  output logic             pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last_r = 12'h000;
  // Idle reading lines show the inverse of the last value, never a stale copy
  always @(posedge mclk_i) if (req_i) last_r <= cur_i;
  assign valid_o = req_i;
  assign cur_o   = req_i ? cur_i : ~last_r;
  assign pin_o   = lvl_i;
endmodule : cll_sensor_model

// ---- testbench.sv ----
// Self-checking bench for the current loop logging control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             mclk_i = 1'b0;
  logic             srst_i = 1'b1;
  logic             req, lvl, tick, pol, sv, pin, mv, wr, warn, avg;
  logic [2:0]       chan, ctl, mch, rch;
  logic [11:0]      cur, scur, raddr, rdata;
  logic [3:0]       per;
  logic [1:0]       gmode, mflag, mdp, mst;
  logic [5:0]       sec, mnt;
  logic [7:0][2:0]  flt;
  logic [7:0][1:0]  typ, sel, dp;
  logic [7:0][14:0] hi, lo;
  logic [7:0][7:0]  uext;
  logic [7:0][8:0]  lext;
  logic [15:0]      mval, wd;
  logic [12:0]      used;
  int               num_errors, checks, wr_cnt;

  cll_sensor_model model (.mclk_i(mclk_i), .req_i(req), .cur_i(cur), .lvl_i(lvl),
    .valid_o(sv), .cur_o(scur), .pin_o(pin));
  cll_logging_ctrl uut (.mclk_i(mclk_i), .srst_i(srst_i), .sample_valid_i(sv),
    .sample_chan_i(chan), .sample_cur_i(scur), .in_type_i(typ), .rec_sel_i(sel),
    .filt_lvl_i(flt), .upper_end_scale_i(hi), .lower_end_scale_i(lo),
    .dec_pos_i(dp), .upper_ext_i(uext), .lower_ext_i(lext), .gate_mode_i(gmode),
    .full_policy_i(pol), .rec_period_i(per), .rtc_tick_i(tick), .rtc_sec_i(sec),
    .rtc_min_i(mnt), .gate_pin_i(pin), .warn_ack_i(ctl[0]), .power_up_i(ctl[1]),
    .download_done_i(ctl[2]), .meas_valid_o(mv), .meas_chan_o(mch),
    .meas_value_o(mval), .meas_flag_o(mflag), .meas_dp_o(mdp), .rec_wr_o(wr),
    .rec_addr_o(raddr), .rec_chan_o(rch), .rec_data_o(rdata), .rec_avg_o(avg),
    .warn_o(warn), .mem_status_o(mst), .used_o(used));

  // Clock, and every record write checked against its sequential address
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    if (wr === 1'b1)
    begin
      check(16'(raddr), 16'(wr_cnt[11:0]));
      wd = {avg, rch, rdata};
      wr_cnt++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One reading; the answer stands for one cycle only, so look right after the edge
  task automatic sample(input logic [2:0] c, input logic [11:0] i, input logic v,
                        input logic [15:0] ev, input logic [1:0] ef);
    @(posedge mclk_i);
    req  <= 1'b1;
    chan <= c;
    cur  <= i;
    @(posedge mclk_i);
    req <= 1'b0;
    #1;
    check(16'(mv), 16'(v));
    if (v) check(16'(mch), 16'(c));
    if (v && ef == 2'h0) check(mval, ev);
    if (v) check(16'(mflag), 16'(ef));
  endtask : sample

  // One clock tick, then the whole scan; n below zero skips the write count
  task automatic rtc(input logic [5:0] s, input int n);
    int w0;
    repeat (3) @(posedge mclk_i);
    w0 = wr_cnt;
    tick <= 1'b1;
    sec  <= s;
    @(posedge mclk_i);
    tick <= 1'b0;
    repeat (12) @(posedge mclk_i);
    if (n >= 0) check(16'(wr_cnt - w0), 16'(n));
  endtask : rtc

  // Bit 0 acknowledge, bit 1 power-up, bit 2 download done
  task automatic pulse(input int b);
    @(posedge mclk_i);
    ctl[b] <= 1'b1;
    @(posedge mclk_i);
    ctl[b] <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : pulse

  task automatic t_scale();
    sample(3'h0, 12'd1200, 1'b1, 16'd500, 2'h0);
    check(16'(mdp), 16'h0003);
    sample(3'h0, 12'd400, 1'b1, 16'd0, 2'h0);
    sample(3'h1, 12'd500, 1'b1, 16'd750, 2'h0);
    sample(3'h0, 12'd390, 1'b1, 16'hFFFA, 2'h0);
    sample(3'h0, 12'd389, 1'b1, 16'h0000, 2'h2);
    sample(3'h0, 12'd2010, 1'b1, 16'd1006, 2'h0);
    sample(3'h0, 12'd2011, 1'b1, 16'h0000, 2'h1);
    sample(3'h1, 12'd0, 1'b1, 16'd1000, 2'h0);
    sample(3'h7, 12'd100, 1'b0, 16'h0000, 2'h0);
  endtask : t_scale

  // Channel 6 is not recorded and channel 7 inactive, so six writes a scan
  task automatic t_sched();
    @(posedge mclk_i);
    per <= 4'h2;
    rtc(6'd3, 0);
    rtc(6'd10, 6);
    gmode <= 2'h1;
    lvl   <= 1'b0;
    rtc(6'd15, 0);
    lvl <= 1'b1;
    rtc(6'd20, 6);
    gmode <= 2'h2;
    rtc(6'd25, 0);
    lvl <= 1'b0;
    rtc(6'd30, 6);
  endtask : t_sched

  task automatic t_stop();
    gmode <= 2'h0;
    per   <= 4'h0;
    typ[7] <= 2'h2;
    sel    <= 16'h5555;
    pulse(2);
    check(16'(used), 16'h0000);
    check(16'(warn), 16'h0000);
    repeat (511) rtc(6'd0, -1);
    rtc(6'd0, 8);
    #1;
    check(16'(used), 16'h1000);
    check(16'(warn), 16'h0001);
    check(16'(mst), 16'h0001);
    rtc(6'd0, 0);
    pulse(0);
    check(16'(warn), 16'h0000);
    pulse(1);
    check(16'(warn), 16'h0001);
    pulse(2);
    check(16'(mst), 16'h0000);
    rtc(6'd0, 8);
  endtask : t_stop

  task automatic t_wrap();
    pol <= 1'b1;
    pulse(2);
    repeat (512) rtc(6'd0, -1);
    check(16'(warn), 16'h0000);
    rtc(6'd0, 8);
    #1;
    check(16'(warn), 16'h0001);
    check(16'(mst), 16'h0002);
  endtask : t_wrap

  // Hour and minute codes, then one averaged record of three readings, the last smoothed
  task automatic t_avg();
    @(posedge mclk_i);
    sel <= 16'h0002;
    per <= 4'hE;
    mnt <= 6'd3;
    rtc(6'd0, 0);
    per <= 4'h8;
    rtc(6'd0, 0);
    sample(3'h0, 12'd1000, 1'b1, 16'd375, 2'h0);
    sample(3'h0, 12'd1200, 1'b1, 16'd500, 2'h0);
    @(posedge mclk_i);
    flt[0] <= 3'h1;
    mnt    <= 6'd4;
    sample(3'h0, 12'd400, 1'b1, 16'd250, 2'h0);
    rtc(6'd0, 1);
    check(wd, 16'h83E8);
  endtask : t_avg

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Main sequence: all inputs set at time zero, reset held for 12 cycles
  initial
  begin
    {req, lvl, tick, pol, ctl, chan, cur, per, gmode, sec, mnt} = '0;
    flt  = '0;
    typ  = 16'h2AA6;
    sel  = 16'h4555;
    dp   = 16'h0003;
    hi   = '0;
    lo   = '0;
    hi[0] = 15'd1000;
    lo[1] = 15'd1000;
    uext = '0;
    lext = '0;
    uext[0] = 8'd10;
    lext[0] = 9'd10;
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_scale();
    t_sched();
    t_stop();
    t_wrap();
    t_avg();
    end_of_test();
  end

  // Guard against a hang anywhere in the sequence
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    num_errors++;
    end_of_test();
  end
endmodule : testbench
